//--- irc_top.sv
// Overview of operation
// (RL1) writes to FEEx_xxxx are interrupt requests
// (RL2) remap disabled: all requests handled as compatibility
// (RL3) compat blocked if extended mode or disallowed
// (RL4) otherwise compat requests pass through unchanged
// (RL5) format bit clear compat, set remappable
// (RL6) format bit4, handle 19:5 plus bit2, subhandle
// (RL7) reserved request bits set: block, reason 20h
// (RL8) extract source, handle, subindex flag, subhandle
// (RL9) index is handle, plus subhandle if valid
// (RL10) index not below table size: reason 21h
// (RL11) entry from cache, else fetched from memory
// (RL12) non-coherent: table fetches do not snoop
// (RL13) table fetch error: block, reason 23h
// (RL14) entry not present: qualified reason 22h
// (RL15) bad entry programming: qualified reason 24h
// (RL16) source verification failure: qualified reason 26h
// (RL17) remap only after all checks pass
// (RL18) remapped interrupt always has trigger level set
// (RL19) every blocked request becomes a fault
// (RL20) qualified faults reported only if not disabled
// (RL21) blocked: drop, one-cycle fault with details
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "irc_map.svh"

module irc_top #(
  parameter int CACHE_DEPTH = 4,
  parameter bit COHERENT = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // inbound write requests
  input wire logic i_req_valid,
  input wire irc_pkg::irc_req_t i_req,
  output logic o_req_ready,
  // table entry fetch port
  output logic o_fetch_valid,
  output logic [31:0] o_fetch_addr,
  output logic o_fetch_nosnoop,
  input wire logic i_fetch_done,
  input wire logic i_fetch_err,
  input wire logic [127:0] i_fetch_data,
  // system bus side
  output logic o_out_valid,
  output irc_pkg::irc_out_t o_out,
  input wire logic i_out_ready,
  // fault recording side
  output logic o_fault_valid,
  output irc_pkg::irc_fault_t o_fault
);

  localparam int IW = (CACHE_DEPTH > 1) ? $clog2(CACHE_DEPTH) : 1;

  generate
    if (CACHE_DEPTH < 2 || (CACHE_DEPTH & (CACHE_DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("CACHE_DEPTH must be a power of two, at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  irc_pkg::irc_state_t state_q;
  irc_pkg::irc_req_t req_q;
  logic [2:0] ctrl_q;
  logic [16:0] tsize_q;
  logic [27:0] tbase_q;
  logic [16:0] index_q;
  logic [127:0] entry_q;
  logic [7:0] last_reason_q;
  logic last_report_q;
  logic [15:0] last_src_q;
  logic [16:0] last_index_q;
  logic [15:0] fault_cnt_q;
  logic [15:0] remap_cnt_q;
  logic [CACHE_DEPTH-1:0] cv_q;
  logic [15:0] ctag_q [CACHE_DEPTH];
  logic [127:0] cdata_q [CACHE_DEPTH];
  logic [IW-1:0] victim_q;

  logic remap_enabled_status;
  logic extended_mode_enable;
  logic compat_allowed_status;
  logic apb_wr;
  logic apb_rd;
  logic flush;
  logic is_intr;
  logic fmt_remap;
  logic subindex_valid;
  logic [15:0] handle;
  logic [15:0] subhandle;
  logic [16:0] index_d;
  logic [CACHE_DEPTH-1:0] hit_vec;
  logic [IW-1:0] hit_idx;
  logic e_present;
  logic e_frd;
  logic e_rsvd_ok;
  logic e_src_ok;
  logic fault_go;
  logic [7:0] fault_reason;

  assign remap_enabled_status = ctrl_q[`IRC_CTRL_REMAP];
  assign extended_mode_enable = ctrl_q[`IRC_CTRL_EXT];
  assign compat_allowed_status = ctrl_q[`IRC_CTRL_COMPAT];

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign o_pready = 1'b1;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && i_penable && !i_pwrite;
  assign flush = apb_wr && (i_paddr == `IRC_OFF_CTRL) &&
                 i_pwdata[`IRC_CTRL_FLUSH];

  // configuration writes
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      ctrl_q <= `IRC_RST_CTRL;
      tsize_q <= `IRC_RST_TSIZE;
      tbase_q <= `IRC_RST_TBASE;
    end
    else if (apb_wr)
    begin
      case (i_paddr)
        `IRC_OFF_CTRL: ctrl_q <= i_pwdata[2:0];
        `IRC_OFF_TSIZE: tsize_q <= i_pwdata[16:0];
        `IRC_OFF_TBASE: tbase_q <= i_pwdata[31:4];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads return zero with an error
  always_comb
  begin
    o_pslverr = 1'b0;
    case (i_paddr)
      `IRC_OFF_CTRL: o_prdata = {28'h0, COHERENT, ctrl_q};
      `IRC_OFF_TSIZE: o_prdata = {15'h0, tsize_q};
      `IRC_OFF_TBASE: o_prdata = {tbase_q, 4'h0};
      `IRC_OFF_FSTAT: o_prdata = {fault_cnt_q, 7'h0, last_report_q,
                                  last_reason_q};
      `IRC_OFF_FSRC: o_prdata = {16'h0, last_src_q};
      `IRC_OFF_FIDX: o_prdata = {15'h0, last_index_q};
      `IRC_OFF_COUNT: o_prdata = {remap_cnt_q, 13'h0, state_q};
      default:
      begin
        o_prdata = 32'h0;
        o_pslverr = i_psel && i_penable;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // request decode on the latched request

  assign is_intr = req_q.addr[31:20] == `IRC_INT_ID; // [RL1]
  assign fmt_remap = req_q.addr[`IRC_ADDR_FMT]; // [RL5] [RL6]
  assign subindex_valid = req_q.addr[`IRC_ADDR_SUBV]; // [RL6] [RL8]
  assign handle = {req_q.addr[`IRC_ADDR_HTOP], req_q.addr[19:5]}; // [RL6]
  assign subhandle = req_q.data[15:0]; // [RL6] [RL8]

  // 17 bits so a wrapped sum still fails the bounds check
  assign index_d = subindex_valid ? {1'b0, handle} + {1'b0, subhandle}
                                  : {1'b0, handle}; // [RL9]

  ////////////////////////////////////////////////////////////////////////
  // entry cache lookup, one comparator per slot

  genvar g;
  generate
    for (g = 0; g < CACHE_DEPTH; g++)
    begin : g_hit
      assign hit_vec[g] = cv_q[g] && (ctag_q[g] == index_d[15:0]);
    end
  endgenerate

  always_comb
  begin
    hit_idx = '0;
    for (int k = 0; k < CACHE_DEPTH; k++)
    begin
      if (hit_vec[k])
        hit_idx = IW'(k);
    end
  end

  // fills replace slots in turn; a flush drops every slot
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn || flush)
    begin
      cv_q <= '0;
      victim_q <= '0;
    end
    // a fill meeting a flush still lands: the set wins
    if (i_rstn && state_q == irc_pkg::IRC_S_FETCH && i_fetch_done &&
        !i_fetch_err)
    begin
      cv_q[victim_q] <= 1'b1;
      victim_q <= victim_q + 1'b1;
    end
  end

  // cache payload needs no reset, guarded by the valid bits
  always_ff @(posedge i_core_clk)
  begin
    if (state_q == irc_pkg::IRC_S_FETCH && i_fetch_done && !i_fetch_err)
    begin
      ctag_q[victim_q] <= index_q[15:0];
      cdata_q[victim_q] <= i_fetch_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // entry checks

  irc_entry_check u_check (
    .i_entry(entry_q),
    .i_src(req_q.src),
    .o_present(e_present),
    .o_frd(e_frd),
    .o_rsvd_ok(e_rsvd_ok),
    .o_src_ok(e_src_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // fault selection per state, first failing check wins

  always_comb
  begin
    fault_go = 1'b0;
    fault_reason = 8'h00;
    case (state_q)
      irc_pkg::IRC_S_DECODE:
      begin
        if (is_intr && remap_enabled_status && !fmt_remap &&
            (extended_mode_enable || !compat_allowed_status))
        begin
          fault_go = 1'b1; // [RL3] [RL19]
          fault_reason = `IRC_FR_COMPAT_BLK;
        end
        else if (is_intr && remap_enabled_status && fmt_remap &&
                 subindex_valid && req_q.data[31:16] != 16'h0)
        begin
          fault_go = 1'b1; // [RL7] [RL19]
          fault_reason = `IRC_FR_RSVD_REQ;
        end
        else if (is_intr && remap_enabled_status && fmt_remap &&
                 index_d >= tsize_q)
        begin
          fault_go = 1'b1; // [RL10] [RL19]
          fault_reason = `IRC_FR_BOUNDS;
        end
      end
      irc_pkg::IRC_S_FETCH:
      begin
        if (i_fetch_done && i_fetch_err)
        begin
          fault_go = 1'b1; // [RL13] [RL19]
          fault_reason = `IRC_FR_FETCH_ERR;
        end
      end
      irc_pkg::IRC_S_CHECK:
      begin
        fault_go = !e_present || !e_rsvd_ok || !e_src_ok; // [RL19]
        if (!e_present)
          fault_reason = `IRC_FR_NOT_PRESENT; // [RL14]
        else if (!e_rsvd_ok)
          fault_reason = `IRC_FR_RSVD_ENTRY; // [RL15]
        else if (!e_src_ok)
          fault_reason = `IRC_FR_SOURCE; // [RL16]
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // processing sequence

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      state_q <= irc_pkg::IRC_S_IDLE;
    else if (fault_go)
      state_q <= irc_pkg::IRC_S_FAULT; // request dropped [RL21]
    else
    begin
      case (state_q)
        irc_pkg::IRC_S_IDLE:
          if (i_req_valid)
            state_q <= irc_pkg::IRC_S_DECODE;
        irc_pkg::IRC_S_DECODE:
          if (is_intr && remap_enabled_status && fmt_remap)
            state_q <= (|hit_vec) ? irc_pkg::IRC_S_CHECK
                                  : irc_pkg::IRC_S_FETCH; // [RL11]
          else
            state_q <= irc_pkg::IRC_S_SEND; // [RL2] [RL4]
        irc_pkg::IRC_S_FETCH:
          if (i_fetch_done)
            state_q <= irc_pkg::IRC_S_CHECK;
        irc_pkg::IRC_S_CHECK:
          state_q <= irc_pkg::IRC_S_SEND; // [RL17]
        irc_pkg::IRC_S_SEND:
          if (i_out_ready)
            state_q <= irc_pkg::IRC_S_IDLE;
        default:
          state_q <= irc_pkg::IRC_S_IDLE;
      endcase
    end
  end

  assign o_req_ready = state_q == irc_pkg::IRC_S_IDLE;
  assign o_out_valid = state_q == irc_pkg::IRC_S_SEND;
  assign o_fault_valid = state_q == irc_pkg::IRC_S_FAULT; // [RL21]
  assign o_fetch_valid = state_q == irc_pkg::IRC_S_FETCH; // [RL11]
  assign o_fetch_nosnoop = !COHERENT; // [RL12]

  // request capture, index and entry hold
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      req_q <= '0;
      index_q <= 17'h0;
      entry_q <= 128'h0;
      o_fetch_addr <= 32'h0;
    end
    else
    begin
      if (o_req_ready && i_req_valid)
        req_q <= i_req;
      if (state_q == irc_pkg::IRC_S_DECODE)
      begin
        index_q <= index_d;
        entry_q <= cdata_q[hit_idx]; // [RL11]
        o_fetch_addr <= {tbase_q, 4'h0} + {11'h0, index_d, 4'h0};
      end
      if (state_q == irc_pkg::IRC_S_FETCH && i_fetch_done)
        entry_q <= i_fetch_data; // [RL11]
    end
  end

  // outgoing request: raw copy, or built from the entry
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_out <= '0;
    else if (state_q == irc_pkg::IRC_S_DECODE)
    begin
      o_out <= '0;
      o_out.kind <= is_intr ? irc_pkg::IRC_K_COMPAT : irc_pkg::IRC_K_MEM;
      o_out.addr <= req_q.addr; // [RL2] [RL4]
      o_out.data <= req_q.data;
    end
    else if (state_q == irc_pkg::IRC_S_CHECK)
    begin
      o_out.kind <= irc_pkg::IRC_K_REMAP; // [RL17]
      o_out.dest <= entry_q[`IRC_E_DST_LO +: 32];
      o_out.vector <= entry_q[`IRC_E_VEC_LO +: 8];
      o_out.dlv_mode <= entry_q[`IRC_E_DLV_LO +: 3];
      o_out.dest_mode <= entry_q[`IRC_E_DM];
      o_out.redir_hint <= entry_q[`IRC_E_RH];
      o_out.trig_level <= 1'b1; // [RL18]
    end
  end

  // fault record: qualified reasons honour the entry's disable bit
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_fault <= '0;
    else if (fault_go)
    begin
      o_fault.reason <= fault_reason; // [RL21]
      o_fault.src <= req_q.src;
      o_fault.index <= (state_q == irc_pkg::IRC_S_DECODE) ? index_d
                                                           : index_q;
      o_fault.report <= !(state_q == irc_pkg::IRC_S_CHECK && e_frd); // [RL20]
    end
  end

  // software view of the last fault and traffic counters
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      last_reason_q <= 8'h00;
      last_report_q <= 1'b0;
      last_src_q <= 16'h0;
      last_index_q <= 17'h0;
      fault_cnt_q <= 16'h0;
    end
    else if (o_fault_valid && o_fault.report)
    begin
      last_reason_q <= o_fault.reason; // [RL20]
      last_report_q <= 1'b1;
      last_src_q <= o_fault.src;
      last_index_q <= o_fault.index;
      fault_cnt_q <= fault_cnt_q + 16'h1;
    end
  end

  // counts remapped interrupts delivered to the bus
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      remap_cnt_q <= 16'h0;
    else if (o_out_valid && i_out_ready &&
             o_out.kind == irc_pkg::IRC_K_REMAP)
      remap_cnt_q <= remap_cnt_q + 16'h1;
  end

endmodule : irc_top

//--- irc_map.svh
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH

// register byte offsets
`define IRC_OFF_CTRL 12'h000
`define IRC_OFF_TSIZE 12'h004
`define IRC_OFF_TBASE 12'h008
`define IRC_OFF_FSTAT 12'h00c
`define IRC_OFF_FSRC 12'h010
`define IRC_OFF_FIDX 12'h014
`define IRC_OFF_COUNT 12'h018

// control register bit positions
`define IRC_CTRL_REMAP 0
`define IRC_CTRL_EXT 1
`define IRC_CTRL_COMPAT 2
`define IRC_CTRL_COHERENT 3
`define IRC_CTRL_FLUSH 4

// reset values
`define IRC_RST_CTRL 3'h0
`define IRC_RST_TSIZE 17'h00000
`define IRC_RST_TBASE 28'h0000000

// request address layout
`define IRC_INT_ID 12'hfee
`define IRC_ADDR_FMT 4
`define IRC_ADDR_SUBV 3
`define IRC_ADDR_HTOP 2

// fault reason codes
`define IRC_FR_RSVD_REQ 8'h20
`define IRC_FR_BOUNDS 8'h21
`define IRC_FR_NOT_PRESENT 8'h22
`define IRC_FR_FETCH_ERR 8'h23
`define IRC_FR_RSVD_ENTRY 8'h24
`define IRC_FR_COMPAT_BLK 8'h25
`define IRC_FR_SOURCE 8'h26

// table entry layout
`define IRC_E_PRESENT 0
`define IRC_E_FRD 1
`define IRC_E_DM 2
`define IRC_E_RH 3
`define IRC_E_TM 4
`define IRC_E_DLV_LO 5
`define IRC_E_RSVA_LO 8
`define IRC_E_VEC_LO 16
`define IRC_E_RSVB_LO 24
`define IRC_E_DST_LO 32
`define IRC_E_SRC_LO 64
`define IRC_E_QUAL_LO 80
`define IRC_E_VTYPE_LO 82
`define IRC_E_RSVC_LO 84

`endif

//--- irc_pkg.sv
package irc_pkg;

  typedef enum logic [2:0] {
    IRC_S_IDLE = 3'b000,
    IRC_S_DECODE = 3'b001,
    IRC_S_FETCH = 3'b010,
    IRC_S_CHECK = 3'b011,
    IRC_S_SEND = 3'b100,
    IRC_S_FAULT = 3'b101
  } irc_state_t;

  typedef enum logic [1:0] {
    IRC_K_MEM = 2'b00,
    IRC_K_COMPAT = 2'b01,
    IRC_K_REMAP = 2'b10
  } irc_kind_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [15:0] src;
  } irc_req_t;

  typedef struct packed {
    irc_kind_t kind;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] dest;
    logic [7:0] vector;
    logic [2:0] dlv_mode;
    logic dest_mode;
    logic redir_hint;
    logic trig_level;
  } irc_out_t;

  typedef struct packed {
    logic [7:0] reason;
    logic report;
    logic [15:0] src;
    logic [16:0] index;
  } irc_fault_t;

endpackage : irc_pkg

//--- irc_entry_check.sv
`timescale 1ns/1ps
`include "irc_map.svh"

module irc_entry_check (
  input wire logic [127:0] i_entry,
  input wire logic [15:0] i_src,
  output logic o_present,
  output logic o_frd,
  output logic o_rsvd_ok,
  output logic o_src_ok
);

  logic [1:0] verify_type;
  logic [1:0] source_mask_qualifier;
  logic [15:0] source_ident_field;
  logic [15:0] cmp_mask;

  assign o_present = i_entry[`IRC_E_PRESENT];
  assign o_frd = i_entry[`IRC_E_FRD];
  assign verify_type = i_entry[`IRC_E_VTYPE_LO +: 2];
  assign source_mask_qualifier = i_entry[`IRC_E_QUAL_LO +: 2];
  assign source_ident_field = i_entry[`IRC_E_SRC_LO +: 16];

  // reserved fields zero, verify type 3 is always a reserved code
  assign o_rsvd_ok = (i_entry[`IRC_E_RSVA_LO +: 8] == 8'h00) &&
                     (i_entry[`IRC_E_RSVB_LO +: 8] == 8'h00) &&
                     (i_entry[127:`IRC_E_RSVC_LO] == 44'h0) &&
                     (verify_type != 2'h3); // [RL15]

  // qualifier widens the match by ignoring low function bits
  always_comb
  begin
    case (source_mask_qualifier)
      2'h1: cmp_mask = 16'hfffb;
      2'h2: cmp_mask = 16'hfff9;
      2'h3: cmp_mask = 16'hfff8;
      default: cmp_mask = 16'hffff;
    endcase
  end

  // source check: none, masked exact match, or bus number range
  always_comb
  begin
    case (verify_type)
      2'h1: o_src_ok = ((i_src ^ source_ident_field) & cmp_mask) == 16'h0;
      2'h2: o_src_ok = (i_src[15:8] >= source_ident_field[15:8]) &&
                       (i_src[15:8] <= source_ident_field[7:0]);
      default: o_src_ok = 1'b1;
    endcase
  end // [RL16]

endmodule : irc_entry_check

//--- irc_far_model.sv
`timescale 1ns/1ps

module irc_far_model (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_fetch_valid,
  input wire logic [31:0] i_fetch_addr,
  output logic o_fetch_done,
  output logic o_fetch_err,
  output logic [127:0] o_fetch_data,
  output logic o_out_ready
);
  logic [127:0] mem [0:15];
  logic [15:0] bad;
  logic [1:0] wait_q;
  int seed = 44996;

  ////////////////////////////////////////////////////////////
  // table memory answers after 1..4 cycles; system bus stalls
  // at random so the held interrupt is exercised
  always_ff @(posedge i_core_clk)
  begin
    o_fetch_done <= 1'b0;
    o_fetch_err <= 1'b0;
    o_fetch_data <= ~o_fetch_data; // idle bus inverts its last value every cycle, so no entry is held
    o_out_ready <= !i_rstn || 1'($random(seed));
    if (!i_rstn)
    begin
      wait_q <= 2'h0;
      o_fetch_data <= {4{32'h5a3c_c3a5}};
    end
    else if (i_fetch_valid)
    begin
      if (wait_q == 2'h0)
      begin
        o_fetch_done <= 1'b1;
        o_fetch_err <= bad[i_fetch_addr[7:4]];
        o_fetch_data <= mem[i_fetch_addr[7:4]];
        wait_q <= 2'($random(seed));
      end
      else
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule : irc_far_model

//--- irc_top_chk.sv
`timescale 1ns/1ps
`include "irc_map.svh"

module irc_top_chk #(
  parameter int CACHE_DEPTH = 4,
  parameter bit COHERENT = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic o_fetch_valid,
  input wire logic [31:0] o_fetch_addr,
  input wire logic o_fetch_nosnoop,
  input wire logic i_fetch_done,
  input wire logic i_fetch_err,
  input wire logic o_out_valid,
  input wire irc_pkg::irc_out_t o_out,
  input wire logic i_out_ready,
  input wire logic o_fault_valid,
  input wire irc_pkg::irc_fault_t o_fault
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////////////////////////
  // request taken, broken fetch, any answer
  sequence s_accept;
    i_req_valid && o_req_ready;
  endsequence
  sequence s_fetch_err;
    o_fetch_valid && i_fetch_done && i_fetch_err;
  endsequence
  sequence s_answer;
    o_out_valid || o_fault_valid;
  endsequence

  chk_fault_pulse: assert property (
    o_fault_valid |=> !o_fault_valid) else $error("fault pulse too long");
  chk_busy_hold: assert property (
    s_accept |=> !o_req_ready) else $error("second request taken");
  chk_answer_due: assert property (
    s_accept |-> ##[2:60] s_answer) else $error("request not answered");
  chk_one_answer: assert property (
    o_fault_valid |-> !o_out_valid) else $error("fault with interrupt");
  chk_err_fault: assert property (
    s_fetch_err |-> ##[1:4] (o_fault_valid &&
      o_fault.reason == `IRC_FR_FETCH_ERR)) else $error("fetch error lost");
  chk_fetch_hold: assert property (
    o_fetch_valid && !i_fetch_done |=> o_fetch_valid &&
      $stable(o_fetch_addr)) else $error("fetch request moved");
  chk_no_snoop: assert property (
    o_fetch_valid |-> o_fetch_nosnoop == !COHERENT) else $error("snoop");
  chk_trig_level: assert property (
    o_out_valid && o_out.kind == irc_pkg::IRC_K_REMAP |->
      o_out.trig_level) else $error("remapped trigger level low");
  chk_out_hold: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
    else $error("interrupt changed before taken");
  chk_unq_report: assert property (
    o_fault_valid && o_fault.reason inside {8'h20, 8'h21, 8'h23, 8'h25}
      |-> o_fault.report) else $error("unqualified fault hidden");
endmodule : irc_top_chk

bind irc_top irc_top_chk #(.CACHE_DEPTH(CACHE_DEPTH), .COHERENT(COHERENT))
  u_irc_top_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
  .o_fetch_valid(o_fetch_valid), .o_fetch_addr(o_fetch_addr),
  .o_fetch_nosnoop(o_fetch_nosnoop), .i_fetch_done(i_fetch_done),
  .i_fetch_err(i_fetch_err), .o_out_valid(o_out_valid), .o_out(o_out),
  .i_out_ready(i_out_ready), .o_fault_valid(o_fault_valid),
  .o_fault(o_fault));

//--- testbench.sv
`timescale 1ns/1ps
`include "irc_map.svh"

module testbench;
  typedef struct packed {
    logic flt;
    logic [7:0] code;
    logic rep;
    logic [31:0] val;
    logic [7:0] vec;
  } irc_exp_t;
  logic clk, rstn, psel, pen, pwr, pready, perr, pe, ok;
  logic rq_v, rq_r, f_v, f_ns, f_d, f_e, o_v, o_r, fl_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, d, dst, faddr, f_a;
  logic [127:0] f_dat;
  logic [7:0] vec;
  logic [2:0] cv [4] = '{3'h7, 3'h1, 3'h3, 3'h5};
  irc_pkg::irc_req_t rq, lr;
  irc_pkg::irc_out_t ob;
  irc_pkg::irc_fault_t fl;
  int fails = 0;
  int checks = 0;
  int seed = 44996;
  int nfetch = 0;
  int n0;
  irc_exp_t expq[$];
  irc_exp_t x, e;

  irc_top u_irc_top (
    .i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .i_req_valid(rq_v), .i_req(rq),
    .o_req_ready(rq_r), .o_fetch_valid(f_v), .o_fetch_addr(f_a),
    .o_fetch_nosnoop(f_ns), .i_fetch_done(f_d), .i_fetch_err(f_e),
    .i_fetch_data(f_dat), .o_out_valid(o_v), .o_out(ob),
    .i_out_ready(o_r), .o_fault_valid(fl_v), .o_fault(fl));
  irc_far_model u_irc_far_model (
    .i_core_clk(clk), .i_rstn(rstn), .i_fetch_valid(f_v),
    .i_fetch_addr(f_a), .o_fetch_done(f_d), .o_fetch_err(f_e),
    .o_fetch_data(f_dat), .o_out_ready(o_r));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic c, input string m);
    checks++;
    if (!c)
    begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // one apb transfer; extra edge so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] dw);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, dw};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rv = prdata;
    pe = perr;
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    chk(rv === v && pe === 1'b0, "register read");
  endtask : rd

  // offer one request, then wait for its noted answer to be seen
  task automatic send(input logic [31:0] a, input logic [31:0] dt,
    input logic [15:0] s, input irc_exp_t ex);
    expq.push_back(ex);
    lr = '{addr: a, data: dt, src: s};
    rq_v <= 1'b1;
    rq <= lr;
    @(posedge clk);
    while (rq_r !== 1'b1)
      @(posedge clk);
    rq_v <= 1'b0;
    rq <= ~rq;
    while (expq.size() != 0)
      @(posedge clk);
  endtask : send

  function automatic irc_exp_t fx(logic [7:0] r, logic p, logic [16:0] i);
    return '{1'b1, r, p, {15'h0, i}, 8'h0};
  endfunction : fx

  function automatic irc_exp_t ox(logic [1:0] k, logic [31:0] v,
    logic [7:0] c);
    return '{1'b0, {6'h0, k}, 1'b0, v, c};
  endfunction : ox

  function automatic logic [31:0] ia(logic [15:0] h, logic sv);
    return {12'hfee, h[14:0], 1'b1, sv, h[15], 2'b00};
  endfunction : ia

  function automatic logic [127:0] ent(logic p, logic fd, logic [1:0] vt,
    logic [15:0] s);
    return {44'h0, vt, 2'b00, s, dst, 8'h0, vec, 14'h0, fd, p};
  endfunction : ent

  // subhandle ignored with the valid flag clear, upper data set
  task automatic tbl(input int i, input logic [15:0] s, input irc_exp_t ex);
    faddr = 32'h1000 + 32'(i) * 32'h10;
    send(ia(16'(i), 1'b0), 32'hffff_0000, s, ex);
  endtask : tbl

  ////////////////////////////////////////////////////////////
  // watcher: fetches and each answer against the oldest note
  always @(posedge clk)
  begin
    if (f_v === 1'b1 && f_d === 1'b1)
    begin
      nfetch++;
      chk(f_a === faddr && f_ns === 1'b1, "fetch request");
    end
    if (fl_v === 1'b1 || (o_v === 1'b1 && o_r === 1'b1))
    begin
      ok = expq.size() != 0;
      x = ok ? expq.pop_front() : '0;
      if (x.flt)
        ok = ok && fl_v === 1'b1 && fl.reason === x.code &&
          fl.report === x.rep && fl.src === lr.src &&
          (x.code inside {8'h20, 8'h25} || fl.index === x.val[16:0]);
      else
        ok = ok && fl_v !== 1'b1 &&
          ob.kind === irc_pkg::irc_kind_t'(x.code[1:0]) &&
          (x.code == 8'h2 ? ob.dest === x.val && ob.vector === x.vec &&
          ob.trig_level === 1'b1 : ob.data === x.val && ob.addr === lr.addr);
      chk(ok, "result differs");
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #(20000 * 8);
    fails++;
    report_and_stop();
  end

  initial
  begin
    rstn = 1'b0;
    {psel, pen, pwr, rq_v, paddr, pwdata, faddr} = '0;
    rq = '0;
    u_irc_far_model.bad = 16'h0008;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`IRC_OFF_CTRL, 32'h0);
    rd(`IRC_OFF_TSIZE, 32'h0);
    rd(`IRC_OFF_TBASE, 32'h0);
    apb(1'b1, `IRC_OFF_TSIZE, 32'h10);
    apb(1'b1, `IRC_OFF_TBASE, 32'h1000);
    rd(`IRC_OFF_TSIZE, 32'h10);
    rd(`IRC_OFF_TBASE, 32'h1000);
    apb(1'b0, 12'h01c, 32'h0);
    chk(pe === 1'b1 && rv === 32'h0, "unmapped read");
    $display("test registers done");
    d = $random(seed);
    send(32'hfee0_1018, d, 16'h1, ox(2'h1, d, 8'h0));
    send(32'h1000_0040, d, 16'h1, ox(2'h0, d, 8'h0));
    foreach (cv[i])
    begin
      apb(1'b1, `IRC_OFF_CTRL, {29'h0, cv[i]});
      d = $random(seed);
      e = cv[i] == 3'h5 ? ox(2'h1, d, 8'h0) : fx(8'h25, 1'b1, 17'h0);
      send(32'hfee0_1008, d, 16'h1, e);
    end
    $display("test formats done");
    faddr = 32'h1030;
    send(ia(16'h3, 1'b0), 32'h0, 16'h1, fx(8'h23, 1'b1, 17'h3));
    send(ia(16'h2, 1'b1), 32'h10006, 16'h1, fx(8'h20, 1'b1, 17'h0));
    send(ia(16'h10, 1'b0), 32'h0, 16'h1, fx(8'h21, 1'b1, 17'h10));
    send(ia(16'ha, 1'b1), 32'h6, 16'h1, fx(8'h21, 1'b1, 17'h10));
    vec = $random(seed);
    dst = $random(seed);
    u_irc_far_model.mem[4] = ent(1'b0, 1'b1, 2'h0, 16'h0);
    u_irc_far_model.mem[5] = ent(1'b0, 1'b0, 2'h0, 16'h0);
    u_irc_far_model.mem[6] = ent(1'b1, 1'b0, 2'h3, 16'h0);
    u_irc_far_model.mem[9] = ent(1'b1, 1'b1, 2'h0, 16'h0) | (128'h1 << 100);
    u_irc_far_model.mem[7] = ent(1'b1, 1'b0, 2'h1, 16'h1234);
    u_irc_far_model.mem[15] = ent(1'b1, 1'b0, 2'h1, 16'h1234);
    u_irc_far_model.mem[10] = ent(1'b1, 1'b0, 2'h0, 16'h0);
    tbl(4, 16'h1, fx(8'h22, 1'b0, 17'h4));
    tbl(5, 16'h1, fx(8'h22, 1'b1, 17'h5));
    tbl(6, 16'h1, fx(8'h24, 1'b1, 17'h6));
    tbl(9, 16'h1, fx(8'h24, 1'b0, 17'h9));
    tbl(7, 16'h1235, fx(8'h26, 1'b1, 17'h7));
    $display("test faults done");
    faddr = 32'h10f0;
    send(ia(16'h9, 1'b1), 32'h6, 16'h1234, ox(2'h2, dst, vec));
    n0 = nfetch;
    tbl(15, 16'h1234, ox(2'h2, dst, vec));
    chk(nfetch == n0, "cache hit fetched");
    apb(1'b1, `IRC_OFF_CTRL, 32'h15);
    tbl(15, 16'h1234, ox(2'h2, dst, vec));
    chk(nfetch == n0 + 1, "flushed entry not fetched");
    repeat (4)
      tbl(10, 16'($random(seed)), ox(2'h2, dst, vec));
    $display("test remap done");
    chk(expq.size() == 0, "answers missing");
    rd(`IRC_OFF_FSTAT, 32'h000a_0126);
    rd(`IRC_OFF_COUNT, 32'h0007_0000);
    report_and_stop();
  end
endmodule : testbench
